// >>> shared/df_seq_pkg.sv
// Purpose: constants, field layout and types for the antenna/sample sequencer
// Assumes: 25 MHz mclk; register port with 8-bit byte addresses
// Notes: offsets and encodings of the register map are fixed here only
package df_seq_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL1 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL2 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_INLINE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PATTERN = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_FLUSH = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PTR = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_LIMIT = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_AMOUNT = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_PINSEL = 8'h40;
  localparam logic [ADDR_W-1:0] PINSEL_MASK = 8'he0;

  // control word 1 fields
  localparam int LEN_LSB = 0;
  localparam int LEN_W = 6;
  localparam int TRIG_BIT = 7;
  localparam int SWI_LSB = 8;
  localparam int FMT_BIT = 12;
  localparam int GSI_LSB = 16;
  localparam int RSI_LSB = 20;
  localparam int AOD_BIT = 24;
  // control word 2 fields
  localparam int SWD_LSB = 0;
  localparam int SMD_LSB = 16;
  localparam int DLY_W = 12;
  // inline control fields
  localparam int INL_EN_BIT = 0;
  localparam int SHORT_LSB = 4;
  localparam int LONG_LSB = 8;
  // antenna pin select fields
  localparam int PIN_LSB = 0;
  localparam int PIN_W = 5;
  localparam int CONN_BIT = 31;
  localparam int CNT_W = 16;

  // reset values
  localparam logic [31:0] CTRL1_RST = 32'h0033_0200;
  localparam logic [31:0] CTRL2_RST = 32'h0000_0000;
  localparam logic [31:0] INLINE_RST = 32'h0000_0330;
  localparam logic [31:0] PINSEL_RST = 32'h0000_0000;

  // antenna and pattern buffer sizes
  localparam int N_ANT = 8;
  localparam int PAT_DEPTH = 16;
  localparam int PAT_AW = 4;
  localparam logic [PAT_AW-1:0] PAT_WRAP = 4'h2;
  localparam logic [PAT_AW-1:0] PAT_LAST = 4'hf;

  // timing
  localparam int CLK_PS = 40000;
  localparam int US_PS = 1000000;
  localparam int STEP_PS = 62500;
  localparam int US_CYC = US_PS / CLK_PS;
  localparam int UNIT8_US = 8;
  localparam int UNIT8_CYC = UNIT8_US * US_CYC;
  localparam int REF_US = 12;
  localparam int REF_CYC = REF_US * US_CYC;
  localparam logic [LEN_W-1:0] MIN_UNITS = 6'h02;

  // switch interval codes
  localparam logic [1:0] SW_1US = 2'h1;
  localparam logic [1:0] SW_2US = 2'h2;
  localparam logic [1:0] SW_4US = 2'h3;

  // trigger and sample format codes
  localparam logic TRIG_CRC = 1'b1;
  localparam logic FMT_IQ = 1'b0;
  localparam logic FMT_MAGPH = 1'b1;
  localparam logic [15:0] SAT_VAL = 16'h8000;
  localparam int IQ_MAX = 2047;
  localparam int IQ_MIN = -2048;

  typedef enum logic [1:0] {
    KIND_AOA = 2'b00,
    KIND_AOD_1US = 2'b01,
    KIND_AOD_2US = 2'b10,
    KIND_RFU = 2'b11
  } tone_kind_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARMED = 3'b001,
    ST_OFFSET = 3'b010,
    ST_REF = 3'b011,
    ST_SLOTS = 3'b100,
    ST_DONE = 3'b101
  } seq_state_type;

  // address hit on a register port access
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // sample interval code to clock cycles (4 us down to 120 ns)
  function automatic logic [CNT_W-1:0] sample_cycles(input logic [2:0] c);
    case (c)
      3'h1: sample_cycles = CNT_W'(4 * US_CYC);
      3'h2: sample_cycles = CNT_W'(2 * US_CYC);
      3'h4: sample_cycles = CNT_W'(US_CYC / 2);
      3'h5: sample_cycles = CNT_W'(US_CYC / 4);
      3'h6: sample_cycles = CNT_W'(US_CYC / 8);
      default: sample_cycles = CNT_W'(US_CYC);
    endcase
  endfunction : sample_cycles

  // switch interval code to clock cycles
  function automatic logic [CNT_W-1:0] switch_cycles(input logic [1:0] c);
    case (c)
      SW_1US: switch_cycles = CNT_W'(US_CYC);
      SW_4US: switch_cycles = CNT_W'(4 * US_CYC);
      default: switch_cycles = CNT_W'(2 * US_CYC);
    endcase
  endfunction : switch_cycles

  // 62.5 ns steps to clock cycles, rounded up
  function automatic logic [CNT_W-1:0] steps_to_cycles(
      input logic [DLY_W-1:0] s);
    int t;
    t = (int'(s) * STEP_PS + CLK_PS - 1) / CLK_PS;
    steps_to_cycles = CNT_W'(t);
  endfunction : steps_to_cycles

endpackage : df_seq_pkg

// >>> rtl/pattern_store.sv
// Purpose: antenna pattern memory with registered read port
// Assumes: one write and one read port on mclk
// Notes: array itself is not reset; read register is
`timescale 1ns/100ps
module pattern_store (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // write port
  input wire logic wr_en,
  input wire logic [df_seq_pkg::PAT_AW-1:0] wr_addr,
  input wire logic [df_seq_pkg::N_ANT-1:0] wr_data,
  // read port
  input wire logic [df_seq_pkg::PAT_AW-1:0] rd_addr,
  output logic [df_seq_pkg::N_ANT-1:0] rd_data_q
);
  import df_seq_pkg::*;

  logic [N_ANT-1:0] mem [PAT_DEPTH];

  // storage write
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule : pattern_store

// >>> rtl/sample_word_pack.sv
// Purpose: packs one captured sample into a 32-bit memory word
// Assumes: demodulator supplies I/Q and magnitude/phase on mclk
// Notes: word and valid appear one cycle after capture
`timescale 1ns/100ps
module sample_word_pack (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // capture request and format
  input wire logic capture,
  input wire logic fmt,
  // sample inputs
  input wire logic [15:0] iq_i,
  input wire logic [15:0] iq_q,
  input wire logic [12:0] mag_in,
  input wire logic [8:0] phase_in,
  // packed word
  output logic [31:0] word_q,
  output logic word_valid_q
);
  import df_seq_pkg::*;

  // saturate anything outside 12-bit signed range
  function automatic logic [15:0] sat12(input logic [15:0] x);
    if ($signed(x) > IQ_MAX || $signed(x) < IQ_MIN) begin
      sat12 = SAT_VAL;
    end else begin
      sat12 = x;
    end
  endfunction : sat12

  wire [31:0] iq_word = {sat12(iq_q), sat12(iq_i)};
  wire [31:0] mp_word = {3'h0, mag_in, {7{phase_in[8]}}, phase_in};
  wire [31:0] sel_word = (fmt == FMT_MAGPH) ? mp_word : iq_word;

  // capture register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      word_q <= '0;
      word_valid_q <= 1'b0;
    end else begin
      word_valid_q <= capture;
      if (capture) begin
        word_q <= sel_word;
      end
    end
  end
endmodule : sample_word_pack

// >>> rtl/direction_finding_cte_control.sv
// Purpose: antenna switching and sample capture during the tone extension
// Assumes: tasks, triggers and samples come from logic on mclk
// Notes: one sample word may wait for memory; later samples drop meanwhile
`timescale 1ns/100ps
module direction_finding_cte_control (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [df_seq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [df_seq_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [df_seq_pkg::DATA_W-1:0] reg_rdata,
  // radio tasks and packet events
  input wire logic transmit_enable_task,
  input wire logic receive_enable_task,
  input wire logic disable_task,
  input wire logic crc_end,
  input wire logic address_match,
  input wire logic cte_detected,
  input wire df_seq_pkg::tone_kind_type tone_extension_kind,
  input wire logic [df_seq_pkg::LEN_W-1:0] inline_cte_time,
  output logic tone_extension_found_event,
  // demodulator samples
  input wire logic [15:0] iq_i,
  input wire logic [15:0] iq_q,
  input wire logic [12:0] mag_in,
  input wire logic [8:0] phase_in,
  // sample memory writes
  output logic dma_valid,
  output logic [31:0] dma_addr,
  output logic [31:0] dma_data,
  input wire logic dma_ready,
  // antenna pins
  output logic [df_seq_pkg::N_ANT-1:0] ant_value,
  output logic [df_seq_pkg::N_ANT-1:0] ant_oe_n,
  output logic [df_seq_pkg::N_ANT*df_seq_pkg::PIN_W-1:0] ant_pin_num
);
  import df_seq_pkg::*;

  // configuration registers
  logic [31:0] ctrl1_q;
  logic [31:0] ctrl2_q;
  logic [31:0] inline_q;
  logic [31:0] ptr_q;
  logic [CNT_W-1:0] limit_q;
  logic [CNT_W-1:0] amount_q;
  logic [31:0] pinsel_q [N_ANT];
  logic [DATA_W-1:0] rdata_d;

  // sequencer state
  seq_state_type state_q;
  seq_state_type state_d;
  logic [CNT_W-1:0] tmr_q;
  logic [CNT_W-1:0] tmr_d;
  logic [CNT_W-1:0] cte_t_q;
  logic [PAT_AW-1:0] idx_q;
  logic [PAT_AW-1:0] idx_d;
  logic own_q;
  logic is_rx_q;

  // sampling state
  logic smp_wait_q;
  logic smp_run_q;
  logic [CNT_W-1:0] smp_tmr_q;
  logic [CNT_W-1:0] smp_t_q;

  // pattern buffer bookkeeping
  logic [PAT_AW:0] pat_cnt_q;
  logic [PAT_AW-1:0] pat_wp_q;
  logic [N_ANT-1:0] pat_rdata;
  logic [N_ANT-1:0] ant_value_q;
  logic found_q;

  // packed sample from formatter
  logic [31:0] word;
  logic word_valid;
  logic dma_valid_q;
  logic [31:0] dma_addr_q;
  logic [31:0] dma_data_q;

  // register port decode
  wire wr_ctrl1 = reg_we && hit(reg_addr, OFF_CTRL1);
  wire wr_ctrl2 = reg_we && hit(reg_addr, OFF_CTRL2);
  wire wr_inline = reg_we && hit(reg_addr, OFF_INLINE);
  wire wr_pat = reg_we && hit(reg_addr, OFF_PATTERN);
  wire flush = reg_we && hit(reg_addr, OFF_FLUSH);
  wire wr_ptr = reg_we && hit(reg_addr, OFF_PTR);
  wire wr_limit = reg_we && hit(reg_addr, OFF_LIMIT);
  wire pin_area = (reg_addr & PINSEL_MASK) == OFF_PINSEL;
  wire [2:0] pin_idx = reg_addr[4:2];

  // configuration fields
  wire [LEN_W-1:0] len_units = ctrl1_q[LEN_LSB +: LEN_W];
  wire trig_sel = ctrl1_q[TRIG_BIT];
  wire [1:0] sw_code = ctrl1_q[SWI_LSB +: 2];
  wire fmt_sel = ctrl1_q[FMT_BIT];
  wire [2:0] gsi_code = ctrl1_q[GSI_LSB +: 3];
  wire [2:0] rsi_code = ctrl1_q[RSI_LSB +: 3];
  wire aod_mode = ctrl1_q[AOD_BIT];
  wire [DLY_W-1:0] sw_delay = ctrl2_q[SWD_LSB +: DLY_W];
  wire [DLY_W-1:0] smp_delay = ctrl2_q[SMD_LSB +: DLY_W];
  wire inline_en = inline_q[INL_EN_BIT];
  wire [2:0] short_code = inline_q[SHORT_LSB +: 3];
  wire [2:0] long_code = inline_q[LONG_LSB +: 3];

  // trigger selection
  wire trig = (trig_sel == TRIG_CRC) ? crc_end : address_match;
  wire task_go = transmit_enable_task | receive_enable_task;
  wire sw_mode_ok = transmit_enable_task ? aod_mode : !aod_mode;

  // extension length: register units, or packet units with minimum
  wire [LEN_W-1:0] inl_units =
    (inline_cte_time < MIN_UNITS) ? MIN_UNITS : inline_cte_time;
  wire [LEN_W-1:0] units = inline_en ? inl_units : len_units;
  wire [CNT_W-1:0] cte_len_cyc = CNT_W'(units * UNIT8_CYC);

  // post-reference sample interval selection
  wire kind_short = tone_extension_kind == KIND_AOD_1US;
  wire kind_long = tone_extension_kind == KIND_AOD_2US;
  wire [2:0] aod_code = kind_short ? short_code :
                        kind_long ? long_code : gsi_code;
  wire [2:0] aoa_code = (sw_code == SW_2US) ? short_code :
                        (sw_code == SW_4US) ? long_code : gsi_code;
  wire [2:0] inl_code = aod_mode ? aod_code : aoa_code;
  wire [2:0] post_code = inline_en ? inl_code : gsi_code;

  // interval lengths in cycles
  wire [CNT_W-1:0] sw_cyc = switch_cycles(sw_code);
  wire in_ref = smp_t_q < CNT_W'(REF_CYC);
  wire [CNT_W-1:0] smp_cyc = in_ref ? sample_cycles(rsi_code)
                                    : sample_cycles(post_code);

  // next pattern index with wrap to entry 2
  wire [PAT_AW:0] idx_inc = {1'b0, idx_q} + 1'b1;
  wire [PAT_AW-1:0] next_idx =
    (idx_inc >= pat_cnt_q) ? PAT_WRAP : idx_inc[PAT_AW-1:0];
  wire [PAT_AW-1:0] wp_next =
    (pat_wp_q == PAT_LAST) ? PAT_WRAP : pat_wp_q + 1'b1;
  wire cte_over = cte_t_q >= cte_len_cyc;
  wire seq_timing = (state_q == ST_REF) || (state_q == ST_SLOTS);

  // sampling control
  wire smp_start = trig && is_rx_q && (state_q == ST_ARMED);
  wire smp_go = smp_wait_q && (smp_tmr_q == '0);
  wire smp_end = smp_run_q && (smp_t_q >= cte_len_cyc);
  wire capture = smp_run_q && !smp_end && (smp_tmr_q == '0);
  wire room = amount_q < limit_q;
  wire issue = word_valid && room && !dma_valid_q;
  wire accepted = dma_valid_q && dma_ready;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    tmr_d = tmr_q - 1'b1;
    idx_d = idx_q;
    unique case (state_q)
      ST_IDLE, ST_DONE: begin
        tmr_d = tmr_q;
      end
      ST_ARMED: begin
        tmr_d = tmr_q;
        if (trig) begin
          state_d = ST_OFFSET;
          tmr_d = steps_to_cycles(sw_delay);
        end
      end
      ST_OFFSET: begin
        if (tmr_q == '0) begin
          state_d = ST_REF;
          idx_d = PAT_AW'(1);
          tmr_d = CNT_W'(REF_CYC - 1);
        end
      end
      ST_REF: begin
        if (tmr_q == '0) begin
          state_d = ST_SLOTS;
          idx_d = next_idx;
          tmr_d = sw_cyc - 1'b1;
        end
      end
      ST_SLOTS: begin
        if (tmr_q == '0 && cte_over) begin
          state_d = ST_DONE;
          idx_d = '0;
        end else if (tmr_q == '0) begin
          idx_d = next_idx;
          tmr_d = sw_cyc - 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        tmr_d = '0;
      end
    endcase
    if (task_go) begin
      state_d = ST_ARMED;
      idx_d = '0;
      tmr_d = '0;
    end
    if (disable_task) begin
      state_d = ST_IDLE;
      tmr_d = '0;
    end
  end

  // sequencer registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      tmr_q <= '0;
      idx_q <= '0;
      cte_t_q <= '0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      idx_q <= idx_d;
      cte_t_q <= seq_timing ? cte_t_q + 1'b1 : '0;
    end
  end

  // pin ownership and receive flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      own_q <= 1'b0;
      is_rx_q <= 1'b0;
    end else if (disable_task) begin
      own_q <= 1'b0;
      is_rx_q <= 1'b0;
    end else if (task_go) begin
      own_q <= sw_mode_ok;
      is_rx_q <= receive_enable_task;
    end
  end

  // sample timing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      smp_wait_q <= 1'b0;
      smp_run_q <= 1'b0;
      smp_tmr_q <= '0;
      smp_t_q <= '0;
    end else if (disable_task || task_go || smp_end) begin
      smp_wait_q <= 1'b0;
      smp_run_q <= 1'b0;
      smp_tmr_q <= '0;
      smp_t_q <= '0;
    end else if (smp_start) begin
      smp_wait_q <= 1'b1;
      smp_tmr_q <= steps_to_cycles(smp_delay);
    end else if (smp_go) begin
      smp_wait_q <= 1'b0;
      smp_run_q <= 1'b1;
    end else if (smp_wait_q || smp_run_q) begin
      smp_t_q <= smp_run_q ? smp_t_q + 1'b1 : smp_t_q;
      smp_tmr_q <= capture ? smp_cyc - 1'b1 : smp_tmr_q - 1'b1;
    end
  end

  // pattern buffer write pointer and fill count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pat_cnt_q <= '0;
      pat_wp_q <= '0;
    end else if (flush) begin
      pat_cnt_q <= '0;
      pat_wp_q <= '0;
    end else if (wr_pat) begin
      pat_wp_q <= wp_next;
      if (pat_cnt_q != (PAT_AW+1)'(PAT_DEPTH)) begin
        pat_cnt_q <= pat_cnt_q + 1'b1;
      end
    end
  end

  // pattern memory
  pattern_store u_pattern_store (
    .mclk(mclk),
    .rst(rst),
    .wr_en(wr_pat),
    .wr_addr(pat_wp_q),
    .wr_data(reg_wdata[N_ANT-1:0]),
    .rd_addr(idx_q),
    .rd_data_q(pat_rdata)
  );

  // antenna outputs per pin
  genvar n;
  generate
    for (n = 0; n < N_ANT; n++) begin : g_ant
      wire drive = own_q && pinsel_q[n][CONN_BIT];
      assign ant_oe_n[n] = !drive;
      assign ant_pin_num[n*PIN_W +: PIN_W] = pinsel_q[n][PIN_LSB +: PIN_W];
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          pinsel_q[n] <= PINSEL_RST;
          ant_value_q[n] <= 1'b0;
        end else begin
          if (reg_we && pin_area && pin_idx == 3'(n)) begin
            pinsel_q[n] <= reg_wdata;
          end
          ant_value_q[n] <= drive && pat_rdata[n];
        end
      end
    end
  endgenerate
  assign ant_value = ant_value_q;

  // sample word formatter
  sample_word_pack u_sample_word_pack (
    .mclk(mclk),
    .rst(rst),
    .capture(capture),
    .fmt(fmt_sel),
    .iq_i(iq_i),
    .iq_q(iq_q),
    .mag_in(mag_in),
    .phase_in(phase_in),
    .word_q(word),
    .word_valid_q(word_valid)
  );

  // memory write request and transferred count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dma_valid_q <= 1'b0;
      dma_addr_q <= '0;
      dma_data_q <= '0;
      amount_q <= '0;
    end else begin
      if (issue) begin
        dma_valid_q <= 1'b1;
        dma_addr_q <= ptr_q + {14'h0, amount_q, 2'h0};
        dma_data_q <= word;
      end else if (accepted) begin
        dma_valid_q <= 1'b0;
      end
      if (receive_enable_task) begin
        amount_q <= '0;
      end else if (accepted) begin
        amount_q <= amount_q + 1'b1;
      end
    end
  end
  assign dma_valid = dma_valid_q;
  assign dma_addr = dma_addr_q;
  assign dma_data = dma_data_q;

  // extension found event
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      found_q <= 1'b0;
    end else begin
      found_q <= cte_detected && is_rx_q;
    end
  end
  assign tone_extension_found_event = found_q;

  // configuration register writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
      inline_q <= INLINE_RST;
      ptr_q <= '0;
      limit_q <= '0;
    end else begin
      if (wr_ctrl1) ctrl1_q <= reg_wdata;
      if (wr_ctrl2) ctrl2_q <= reg_wdata;
      if (wr_inline) inline_q <= reg_wdata;
      if (wr_ptr) ptr_q <= reg_wdata;
      if (wr_limit) limit_q <= reg_wdata[CNT_W-1:0];
    end
  end

  // read data selection
  always_comb begin
    rdata_d = '0;
    if (pin_area) begin
      rdata_d = pinsel_q[pin_idx];
    end else begin
      case (reg_addr)
        OFF_CTRL1: rdata_d = ctrl1_q;
        OFF_CTRL2: rdata_d = ctrl2_q;
        OFF_INLINE: rdata_d = inline_q;
        OFF_PATTERN: rdata_d = {27'h0, pat_cnt_q};
        OFF_PTR: rdata_d = ptr_q;
        OFF_LIMIT: rdata_d = {16'h0, limit_q};
        OFF_AMOUNT: rdata_d = {16'h0, amount_q};
        OFF_STATUS: rdata_d = {24'h0, smp_run_q, is_rx_q, own_q,
                               2'h0, state_q};
        default: rdata_d = '0;
      endcase
    end
  end

  // read data register, valid one cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_re) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : direction_finding_cte_control

// >>> verification/df_chk.sv
// Purpose: port checks for the tone extension sequencer
// Assumes: one mclk domain, reset rst
// Notes: shadows format and antenna 0 connect bits
`timescale 1ns/100ps
module df_chk
  import df_seq_pkg::*;
(
  // clock, reset and register port
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  // events and memory side
  input wire logic cte_detected,
  input wire logic tone_extension_found_event,
  input wire logic disable_task,
  input wire logic dma_valid,
  input wire logic [31:0] dma_addr,
  input wire logic [31:0] dma_data,
  input wire logic dma_ready,
  // antenna side
  input wire logic [7:0] ant_oe_n,
  input wire logic [39:0] ant_pin_num
);
  logic fmt_q;
  logic conn_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // shadow copies of the format and connect bits
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fmt_q <= 1'b0;
      conn_q <= 1'b0;
    end else if (reg_we) begin
      if (reg_addr == OFF_CTRL1) fmt_q <= reg_wdata[FMT_BIT];
      if (reg_addr == OFF_PINSEL) conn_q <= reg_wdata[CONN_BIT];
    end
  end
  a_found_cause: assert property (
    tone_extension_found_event |-> $past(cte_detected))
    else $error("event without a detected extension");
  a_found_once: assert property (
    tone_extension_found_event |=> !tone_extension_found_event)
    else $error("event longer than one cycle");
  a_dma_hold: assert property (
    dma_valid && !dma_ready |=>
    dma_valid && $stable(dma_addr) && $stable(dma_data))
    else $error("memory write changed before accepted");
  a_pin_release: assert property (
    disable_task |-> ##[1:3] ant_oe_n == 8'hff)
    else $error("pins not released after disable");
  a_pin_map: assert property (
    reg_we && reg_addr == OFF_PINSEL |=>
    ant_pin_num[4:0] == $past(reg_wdata[4:0]))
    else $error("pin number not taken from select");
  a_disc_pin: assert property (
    !conn_q |-> ant_oe_n[0])
    else $error("disconnected pin driven");
  a_iq_low: assert property (
    dma_valid && !fmt_q |-> &dma_data[15:11] ||
    ~|dma_data[15:11] || dma_data[15:0] == SAT_VAL)
    else $error("low half not a 12-bit value");
  a_iq_high: assert property (
    dma_valid && !fmt_q |-> &dma_data[31:27] ||
    ~|dma_data[31:27] || dma_data[31:16] == SAT_VAL)
    else $error("high half not a 12-bit value");
  a_mp_top: assert property (
    dma_valid && fmt_q |-> dma_data[31:29] == 3'h0 &&
    dma_data[15:9] == {7{dma_data[8]}})
    else $error("magnitude/phase word badly packed");
endmodule : df_chk
bind direction_finding_cte_control df_chk df_chk_inst (.*);

// >>> verification/dma_mem.sv
// Purpose: memory side model taking sample words
// Assumes: valid holds until ready
// Notes: slow mode grants after three waiting cycles
`timescale 1ns/100ps
module dma_mem (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // write request and pace
  input wire logic dma_valid,
  input wire logic [31:0] dma_addr,
  input wire logic [31:0] dma_data,
  input wire logic slow,
  output logic dma_ready,
  // last accepted word
  output logic [31:0] last_addr,
  output logic [31:0] last_data
);
  logic [1:0] wait_q;
  // grant at once or after the wait count
  assign dma_ready = dma_valid && (!slow || wait_q == 2'h3);
  // record each accepted word
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_q <= 2'h0;
      last_addr <= 32'h0;
      last_data <= 32'h0;
    end else if (dma_ready) begin
      wait_q <= 2'h0;
      last_addr <= dma_addr;
      last_data <= dma_data;
    end else if (dma_valid) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule : dma_mem

// >>> verification/direction_finding_cte_control_tb.sv
// Purpose: self-checking bench for the sequencer
// Assumes: 25 MHz mclk, slow memory side
// Notes: register table first, then two receive runs
`timescale 1ns/100ps
module direction_finding_cte_control_tb;
  import df_seq_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d;} row_type;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [5:0] ev = 6'h0;
  logic transmit_enable_task, receive_enable_task, disable_task;
  logic crc_end, address_match, cte_detected;
  tone_kind_type tone_extension_kind = KIND_AOA;
  logic [5:0] inline_cte_time = 6'h2;
  logic [15:0] iq_i = 16'h0;
  logic [15:0] iq_q = 16'h0;
  logic [12:0] mag_in = 13'h0;
  logic [8:0] phase_in = 9'h0;
  logic slow = 1'b1;
  logic [31:0] reg_rdata, dma_addr, dma_data, last_addr, last_data;
  logic [7:0] ant_value, ant_oe_n;
  logic [39:0] ant_pin_num;
  logic tone_extension_found_event, dma_valid, dma_ready;
  int fail_count = 0;
  int checks = 0;
  row_type rows [5] = '{'{OFF_CTRL1, CTRL1_RST}, '{OFF_CTRL2, CTRL2_RST},
    '{OFF_INLINE, INLINE_RST}, '{OFF_PINSEL, PINSEL_RST}, '{8'h3c, 32'h0}};
  assign {transmit_enable_task, receive_enable_task, disable_task,
    crc_end, address_match, cte_detected} = ev;
  direction_finding_cte_control direction_finding_cte_control_inst (.*);
  dma_mem dma_mem_inst (.*);
  // clock
  always #20 mclk = ~mclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic pulse(input logic [5:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 6'h0;
  endtask : pulse
  task automatic hold(input int n, input logic [7:0] e);
    repeat (n) @(posedge mclk);
    #1 chk(ant_value, e);
  endtask : hold
  task automatic give_verdict();
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  // watchdog
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i]) rd(rows[i].a, rows[i].d);
    for (int k = 0; k < 3; k++) wr(OFF_PATTERN, 32'h1 << k);
    rd(OFF_PATTERN, 32'h3);
    wr(OFF_FLUSH, 32'h1);
    rd(OFF_PATTERN, 32'h0);
    for (int k = 0; k < 3; k++) wr(OFF_PATTERN, 32'h1 << k);
    wr(OFF_CTRL1, 32'h0033_0282);
    wr(OFF_PINSEL, 32'h8000_0005);
    #1 chk(ant_pin_num[4:0], 32'h5);
    // connect antennas 1 and 2 so entries 1 and 2 reach the pins
    wr(OFF_PINSEL + 8'h04, 32'h8000_0006);
    wr(OFF_PINSEL + 8'h08, 32'h8000_0007);
    wr(OFF_PTR, 32'h1000);
    wr(OFF_LIMIT, 32'h3);
    iq_i <= 16'h0123;
    iq_q <= 16'h7000;
    pulse(6'h10);
    #1 chk(ant_oe_n, 8'hf8);
    hold(3, 8'h01);
    pulse(6'h01);
    #1 chk(tone_extension_found_event, 32'h1);
    pulse(6'h04);
    hold(6, 8'h02);
    hold(319, 8'h04);
    hold(50, 8'h04);
    hold(225, 8'h01);
    rd(OFF_AMOUNT, 32'h3);
    chk(last_addr, 32'h1008);
    chk(last_data, 32'h8000_0123);
    pulse(6'h08);
    repeat (3) @(posedge mclk);
    #1 chk(ant_oe_n, 8'hff);
    // second run: address match trigger, magnitude/phase words
    wr(OFF_CTRL1, 32'h0033_1202);
    mag_in <= 13'h1abc;
    phase_in <= 9'h1f0;
    pulse(6'h10);
    pulse(6'h04);
    rd(OFF_STATUS, 32'h61);
    pulse(6'h02);
    repeat (100) @(posedge mclk);
    chk(last_data, 32'h1abc_fff0);
    chk(last_addr, 32'h1008);
    rd(OFF_AMOUNT, 32'h3);
    give_verdict();
  end
endmodule : direction_finding_cte_control_tb
